// *** core/fsp_map.svh ***
/*
  Offsets, field positions, reset values and cycle counts of the flash
  self-programming control block.
  Assumes it is included by bare name from files under core/.
*/
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define FSP_CSR_OFFSET 6'h37
`define FSP_CSR_RESET 8'h00
`define FSP_BIT_IRQ_EN 7
`define FSP_BIT_BUSY 6
`define FSP_BIT_SIG_READ 5
`define FSP_BIT_REENABLE 4
`define FSP_BIT_LOCK_WRITE 3
`define FSP_BIT_PAGE_WRITE 2
`define FSP_BIT_PAGE_ERASE 1
`define FSP_BIT_PROG_EN 0

// ----------------------------------------------------------------------------
// Accepted low five bit command patterns
// ----------------------------------------------------------------------------
`define FSP_PAT_REENABLE 5'h11
`define FSP_PAT_LOCK 5'h09
`define FSP_PAT_PAGE_WRITE 5'h05
`define FSP_PAT_PAGE_ERASE 5'h03
`define FSP_PAT_FILL 5'h01

// ----------------------------------------------------------------------------
// Flash geometry (word addresses)
// ----------------------------------------------------------------------------
`define FSP_PAGE_WORDS 64
`define FSP_PROT_START 14'h3800
`define FSP_BOOT_START_256 14'h3f00
`define FSP_BOOT_START_512 14'h3e00
`define FSP_BOOT_START_1K 14'h3c00
`define FSP_BOOT_START_2K 14'h3800
`define FSP_ERASED_WORD 16'hffff
`define FSP_BOOT_LOCK_MASK 8'h3c
`define FSP_LOCK_RESET 8'hff
`define FSP_BLOCKED_BYTE 8'hff

// ----------------------------------------------------------------------------
// Timed windows, in clock cycles
// ----------------------------------------------------------------------------
`define FSP_SPM_WINDOW_CYC 3'h4
`define FSP_LDP_WINDOW_CYC 3'h3

`endif

// *** core/fsp_pkg.sv ***
/*
  Types of the flash self-programming control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fsp_pkg;

  // --------------------------------------------------------------------------
  // Sequencer state, Gray coded along idle, armed, programming
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FSP_IDLE  = 2'b00,
    FSP_ARMED = 2'b01,
    FSP_PROG  = 2'b11
  } fsp_state_t;

  // Index of each one-hot command flag held while armed
  typedef enum logic [1:0] {
    FSP_CMD_ERASE = 2'h0,
    FSP_CMD_WRITE = 2'h1,
    FSP_CMD_LOCK  = 2'h2,
    FSP_CMD_REEN  = 2'h3
  } fsp_cmd_idx_t;

endpackage : fsp_pkg

// *** core/fsp_page_buffer.sv ***
/*
  Temporary page buffer: one page of sixteen-bit words with a loaded flag
  per word. Unloaded words read back as erased.
  Assumes one clock; the flash array reads it while a page write runs.
*/
`timescale 1ns/1ps
`include "fsp_map.svh"

module fsp_page_buffer
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic [5:0] wrIdx,
  input wire logic [15:0] wrData,
  input wire logic clear,
  input wire logic [5:0] rdIdx,
  output logic [15:0] rdData,
  output logic anyLoaded
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [15:0] mem [`FSP_PAGE_WORDS]; // One page of words [RULE_02]
  logic [`FSP_PAGE_WORDS-1:0] loaded_q; // Word holds fill data

  // Word storage; no reset needed, loaded flags guard it
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrIdx] <= wrData;
    end
  end

  // Loaded flag per word; clear discards the whole page
  for (genvar i = 0; i < `FSP_PAGE_WORDS; i++)
  begin : g_loaded
    always_ff @(posedge clk)
    begin
      if (!rstn || clear)
      begin
        loaded_q[i] <= 1'b0;
      end
      else if (wrEn && (wrIdx == 6'(i)))
      begin
        loaded_q[i] <= 1'b1;
      end
    end
  end

  // Registered read port toward the flash array
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdData <= `FSP_ERASED_WORD;
    end
    else
    begin
      rdData <= loaded_q[rdIdx] ? mem[rdIdx] : `FSP_ERASED_WORD;
    end
  end

  assign anyLoaded = |loaded_q;

endmodule : fsp_page_buffer

// *** core/fsp_control.sv ***
/*
  Flash self-programming control: control/status register, timed command
  windows, page buffer fill, page erase/write launch, region busy tracking,
  lock/fuse/signature reads and the ready interrupt request.
  Assumes the CPU core, the flash array and the fuses share clk.
*/
// Summary of operation
// RULE_01: Boot size code selects boot start address
// RULE_02: Pages hold 64 words; page-wide operations
// RULE_03: Region split at word address 0x3800
// RULE_04: Page from Z13:Z7, word from Z6:Z1
// RULE_05: Software keeps word index zero on write
// RULE_06: Z0 selects byte on program loads
// RULE_07: Ready request while enabled and idle
// RULE_08: Busy flag set, blocks concurrent region reads
// RULE_09: Busy clears on re-enable or buffer fill
// RULE_10: Signature read armed; store does nothing
// RULE_11: Re-enable region, refused while programming
// RULE_12: Re-enable write aborts buffer fill
// RULE_13: Store writes boot lock bits from R0
// RULE_14: Load returns lock or fuse bits
// RULE_15: Store programs addressed page from buffer
// RULE_16: Store erases addressed page
// RULE_17: CPU halted while programming protected region
// RULE_18: Plain enable store fills buffer word
// RULE_19: Enable opens four cycle store window
// RULE_20: Only five low-bit patterns are accepted
// RULE_21: Software runs one store operation at once
// RULE_22: Software waits EEPROM, masks interrupts
// RULE_23: Timeout clears all command bits together
`timescale 1ns/1ps
`include "fsp_map.svh"

module fsp_control
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [5:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic spmExec,
  input wire logic ldpExec,
  input wire logic [15:0] zPointer,
  input wire logic [15:0] r1r0Word,
  output logic [7:0] ldpData,
  output logic ldpValid,
  input wire logic globalIrqEn,
  output logic readyIrq,
  input wire logic [1:0] bootSizeSel,
  output logic [13:0] bootStart,
  input wire logic [7:0] fuseBits,
  input wire logic [7:0] sigRowByte,
  input wire logic [15:0] flashRdWord,
  input wire logic [13:0] rdAddr,
  output logic rdBlocked,
  output logic cpuHalt,
  output logic flashOpStart,
  output logic flashOpErase,
  output logic [6:0] flashPage,
  input wire logic flashDone,
  input wire logic [5:0] bufRdIdx,
  output logic [15:0] bufRdData,
  output logic [7:0] lockBits
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  fsp_state_t state_q; // Sequencer state
  logic [2:0] winCnt_q; // Cycles left in the store window
  logic [3:0] cmd_q; // One-hot armed command
  logic sigRead_q; // Signature read armed
  logic irqEn_q; // Ready interrupt enable
  logic busy_q; // Concurrent region busy
  logic opProt_q; // Running operation targets protected region
  logic wrHit; // Write to the control register
  logic patOk; // Low five bits form a legal pattern
  logic armWr; // Accepted arming write
  logic spmAct; // Store instruction acted on this cycle
  logic opStart; // Page erase or write launches
  logic winEnd; // Window expires this cycle
  logic ldpWin; // Load window still open
  logic zInProt; // Pointer addresses protected region
  logic isFill; // Plain enable armed
  logic bufClear; // Discard page buffer
  logic bufLoaded; // Buffer holds fill data
  logic progEn; // Store-program-enable status bit

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  // Register write decode and command filters
  always_comb
  begin
    wrHit = regWrEn && (regAddr == `FSP_CSR_OFFSET);
    patOk = (regWrData[4:0] == `FSP_PAT_REENABLE) ||
            (regWrData[4:0] == `FSP_PAT_LOCK) ||
            (regWrData[4:0] == `FSP_PAT_PAGE_WRITE) ||
            (regWrData[4:0] == `FSP_PAT_PAGE_ERASE) ||
            (regWrData[4:0] == `FSP_PAT_FILL); // [RULE_20]
    // Arming is refused while a page operation runs [RULE_11] [RULE_21]
    armWr = wrHit && patOk && (state_q != FSP_PROG);
    // An accepted arming write in the same cycle as a store wins; the store is dropped
    spmAct = spmExec && (state_q == FSP_ARMED) && !armWr;
    opStart = spmAct && (cmd_q[FSP_CMD_ERASE] || cmd_q[FSP_CMD_WRITE]);
    winEnd = (state_q == FSP_ARMED) && !armWr && !spmAct && (winCnt_q == 3'h1);
    ldpWin = (state_q == FSP_ARMED) &&
             (winCnt_q > (`FSP_SPM_WINDOW_CYC - `FSP_LDP_WINDOW_CYC));
    isFill = (cmd_q == 4'h0) && !sigRead_q;
    zInProt = zPointer[14:1] >= `FSP_PROT_START; // [RULE_03]
    progEn = state_q != FSP_IDLE;
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Idle, armed for a timed store, or waiting for the flash to finish
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= FSP_IDLE;
    end
    else
    begin
      unique case (state_q)
        FSP_IDLE:
        begin
          if (armWr)
          begin
            state_q <= FSP_ARMED;
          end
        end
        FSP_ARMED:
        begin
          if (armWr)
          begin
            state_q <= FSP_ARMED; // Rewrite restarts the window
          end
          else if (opStart)
          begin
            state_q <= FSP_PROG; // Enable stays set while programming [RULE_19]
          end
          else if (spmAct || winEnd)
          begin
            state_q <= FSP_IDLE; // Done or timed out [RULE_19]
          end
        end
        FSP_PROG:
        begin
          if (flashDone)
          begin
            state_q <= FSP_IDLE;
          end
        end
        default:
        begin
          state_q <= FSP_IDLE; // Illegal code recovers to idle
        end
      endcase
    end
  end

  // Store window counter: four cycles after an accepted write
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      winCnt_q <= 3'h0;
    end
    else if (armWr)
    begin
      winCnt_q <= `FSP_SPM_WINDOW_CYC; // [RULE_19]
    end
    else if ((state_q == FSP_ARMED) && (winCnt_q != 3'h0))
    begin
      winCnt_q <= winCnt_q - 3'h1;
    end
    else
    begin
      winCnt_q <= 3'h0;
    end
  end

  // Armed command flags, all cleared together at timeout or completion
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cmd_q <= 4'h0;
      sigRead_q <= 1'b0;
    end
    else if (armWr)
    begin
      cmd_q <= regWrData[4:1];
      sigRead_q <= regWrData[`FSP_BIT_SIG_READ] && (regWrData[4:0] == `FSP_PAT_FILL);
    end
    else if (winEnd || (spmAct && !opStart) || ((state_q == FSP_PROG) && flashDone))
    begin
      cmd_q <= 4'h0; // [RULE_23] [RULE_13] [RULE_15] [RULE_16]
      sigRead_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Control and status register
  // --------------------------------------------------------------------------
  // Interrupt enable takes any write, legal pattern or not
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      irqEn_q <= 1'(`FSP_CSR_RESET >> `FSP_BIT_IRQ_EN);
    end
    else if (wrHit)
    begin
      irqEn_q <= regWrData[`FSP_BIT_IRQ_EN];
    end
  end

  // Read port; unmapped reads answer zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      regRdData <= `FSP_CSR_RESET;
    end
    else if (regRdEn && (regAddr == `FSP_CSR_OFFSET))
    begin
      regRdData <= {irqEn_q, busy_q, sigRead_q, cmd_q, progEn};
    end
    else
    begin
      regRdData <= 8'h00;
    end
  end

  // Ready request as long as enabled and no store is pending
  assign readyIrq = irqEn_q && globalIrqEn && !progEn; // [RULE_07]

  // --------------------------------------------------------------------------
  // Region busy, halt and read blocking
  // --------------------------------------------------------------------------
  // Busy sets on programming the concurrent region; fill or re-enable clear
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      busy_q <= 1'b0;
    end
    else if (opStart && !zInProt)
    begin
      busy_q <= 1'b1; // [RULE_08]
    end
    else if (spmAct && (cmd_q[FSP_CMD_REEN] || isFill))
    begin
      busy_q <= 1'b0; // [RULE_09] [RULE_11]
    end
  end

  assign rdBlocked = busy_q && (rdAddr < `FSP_PROT_START); // [RULE_08]
  assign cpuHalt = (state_q == FSP_PROG) && opProt_q; // [RULE_17]

  // --------------------------------------------------------------------------
  // Flash operation launch
  // --------------------------------------------------------------------------
  // Page address comes from the pointer high part; R1:R0 unused
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      flashOpStart <= 1'b0;
      flashOpErase <= 1'b0;
      flashPage <= 7'h00;
      opProt_q <= 1'b0;
    end
    else
    begin
      flashOpStart <= opStart; // [RULE_15] [RULE_16]
      if (opStart)
      begin
        flashOpErase <= cmd_q[FSP_CMD_ERASE];
        flashPage <= zPointer[13:7]; // [RULE_04] [RULE_02]
        opProt_q <= zInProt;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Page buffer
  // --------------------------------------------------------------------------
  // Discard on re-enable during a fill, and after a page write completes
  assign bufClear = (armWr && (regWrData[4:0] == `FSP_PAT_REENABLE) && bufLoaded) ||
                    ((state_q == FSP_PROG) && flashDone && !flashOpErase); // [RULE_12]

  fsp_page_buffer u_buf (
    .clk(clk),
    .rstn(rstn),
    .wrEn(spmAct && isFill), // R1:R0 into word Z6:Z1, Z0 ignored [RULE_18] [RULE_04]
    .wrIdx(zPointer[6:1]),
    .wrData(r1r0Word),
    .clear(bufClear),
    .rdIdx(bufRdIdx),
    .rdData(bufRdData),
    .anyLoaded(bufLoaded)
  );

  // --------------------------------------------------------------------------
  // Lock bits and program loads
  // --------------------------------------------------------------------------
  // Only boot lock bits can be programmed, from R0
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      lockBits <= `FSP_LOCK_RESET;
    end
    else if (spmAct && cmd_q[FSP_CMD_LOCK])
    begin
      lockBits <= lockBits & (r1r0Word[7:0] | ~`FSP_BOOT_LOCK_MASK); // [RULE_13]
    end
  end

  // Load answers one cycle later; special sources inside the load window
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ldpData <= 8'h00;
      ldpValid <= 1'b0;
    end
    else
    begin
      ldpValid <= ldpExec;
      if (ldpExec)
      begin
        if (ldpWin && sigRead_q)
        begin
          ldpData <= sigRowByte; // [RULE_10]
        end
        else if (ldpWin && cmd_q[FSP_CMD_LOCK])
        begin
          ldpData <= zPointer[0] ? fuseBits : lockBits; // [RULE_14]
        end
        else if (busy_q && (zPointer[14:1] < `FSP_PROT_START))
        begin
          ldpData <= `FSP_BLOCKED_BYTE; // [RULE_08]
        end
        else
        begin
          ldpData <= zPointer[0] ? flashRdWord[15:8] : flashRdWord[7:0]; // [RULE_06]
        end
      end
    end
  end

  // Boot section start from the size code
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bootStart <= `FSP_BOOT_START_2K;
    end
    else
    begin
      unique case (bootSizeSel)
        2'b11: bootStart <= `FSP_BOOT_START_256; // [RULE_01]
        2'b10: bootStart <= `FSP_BOOT_START_512;
        2'b01: bootStart <= `FSP_BOOT_START_1K;
        2'b00: bootStart <= `FSP_BOOT_START_2K;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_BOOT_START: assert property ( // [RULE_01]
    ##1 (bootSizeSel == 2'b00) |=> bootStart == 14'h3800)
    else $error("boot start wrong for largest boot size");
  AST_PAGE_IDX: assert property ( // [RULE_04]
    opStart |=> flashOpStart && (flashPage == $past(zPointer[13:7])))
    else $error("page index not taken from pointer");
  AST_IRQ_OFF: assert property ( // [RULE_07]
    armWr |=> !readyIrq)
    else $error("ready request while store pending");
  AST_BUSY_SET: assert property ( // [RULE_08]
    (opStart && !zInProt) |=> busy_q && rdBlocked == (rdAddr < 14'h3800))
    else $error("busy flag or read block missing");
  AST_FILL_CLR: assert property ( // [RULE_09]
    (spmAct && isFill) |=> !busy_q && !progEn)
    else $error("fill did not clear busy or enable");
  AST_WIN_OPEN: assert property ( // [RULE_19]
    armWr ##1 (!spmExec && !regWrEn)[*3] |=> state_q == FSP_ARMED)
    else $error("store window closed too early");
  AST_TIMEOUT: assert property ( // [RULE_23]
    armWr ##1 (!spmExec && !regWrEn)[*4] |=> !progEn && cmd_q == 4'h0 && !sigRead_q)
    else $error("window did not time out cleanly");
  AST_BAD_PAT: assert property ( // [RULE_20]
    (wrHit && !patOk && state_q == FSP_IDLE) |=> state_q == FSP_IDLE)
    else $error("illegal pattern armed the sequencer");
  AST_HALT: assert property ( // [RULE_17]
    (opStart && zInProt) |=> cpuHalt throughout (##[0:2] 1'b1))
    else $error("cpu not halted for protected page");
  AST_HOLD: assert property ( // [RULE_19]
    (state_q == FSP_PROG && !flashDone) |=> progEn && !readyIrq)
    else $error("enable dropped during programming");
  AST_LOCK_RD: assert property ( // [RULE_14]
    (ldpExec && ldpWin && cmd_q[FSP_CMD_LOCK] && !zPointer[0]) |=> ldpData == $past(lockBits))
    else $error("lock bits not returned by load");

  CV_FILL: cover property (spmAct && isFill);
  CV_ERASE: cover property (opStart && cmd_q[FSP_CMD_ERASE] ##[1:20] flashDone);
  CV_TIMEOUT: cover property (winEnd);
  CV_SIG_RD: cover property (ldpExec && ldpWin && sigRead_q);

endmodule : fsp_control

// *** dv/fsp_flash_model.sv ***
/*
  Flash array model: finishes a launched erase or write after a set number
  of cycles and serves a read word derived from the read address.
  Assumes the control block's clk and its synchronous active-low rstn.
*/
`timescale 1ns/1ps

module fsp_flash_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic flashOpStart,
  input wire logic [7:0] opCycles,
  input wire logic [13:0] rdAddr,
  output logic flashDone,
  output logic [15:0] flashRdWord
);
  // --------------------------------------------------------------------------
  // Operation countdown
  // --------------------------------------------------------------------------
  logic [7:0] opCnt_q; // Cycles left in the running operation

  // Load on launch, count down, pulse done for one cycle at the end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      opCnt_q <= 8'h00;
      flashDone <= 1'b0;
    end
    else
    begin
      flashDone <= (opCnt_q == 8'h01);
      if (flashOpStart)
        opCnt_q <= opCycles;
      else if (opCnt_q != 8'h00)
        opCnt_q <= opCnt_q - 8'h01;
    end
  end

  // Low byte is the address, high byte its inverse, so bytes differ
  assign flashRdWord = {~rdAddr[7:0], rdAddr[7:0]};
endmodule : fsp_flash_model

// *** dv/tb.sv ***
/*
  Self-checking bench of the flash self-programming control block.
  Assumes fsp_map.svh on the include path and the flash model beside it.
*/
`timescale 1ns/1ps
`include "fsp_map.svh"

module tb
  import fsp_pkg::*;
;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic clk, rstn, regWrEn, regRdEn, spmExec, ldpExec, globalIrqEn, readyIrq;
  logic ldpValid, rdBlocked, cpuHalt, flashOpStart, flashOpErase, flashDone;
  logic [5:0] regAddr, bufRdIdx;
  logic [7:0] regWrData, regRdData, ldpData, fuseBits, sigRowByte, lockBits;
  logic [15:0] zPointer, r1r0Word, flashRdWord, bufRdData, v;
  logic [13:0] bootStart, rdAddr;
  logic [1:0] bootSizeSel;
  logic [6:0] flashPage;
  logic [13:0] bootTab [4];
  int errors, testsRun, cycles;

  fsp_control i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .spmExec(spmExec),
    .ldpExec(ldpExec), .zPointer(zPointer), .r1r0Word(r1r0Word), .ldpData(ldpData),
    .ldpValid(ldpValid), .globalIrqEn(globalIrqEn), .readyIrq(readyIrq),
    .bootSizeSel(bootSizeSel), .bootStart(bootStart), .fuseBits(fuseBits),
    .sigRowByte(sigRowByte), .flashRdWord(flashRdWord), .rdAddr(rdAddr),
    .rdBlocked(rdBlocked), .cpuHalt(cpuHalt), .flashOpStart(flashOpStart),
    .flashOpErase(flashOpErase), .flashPage(flashPage), .flashDone(flashDone),
    .bufRdIdx(bufRdIdx), .bufRdData(bufRdData), .lockBits(lockBits));

  fsp_flash_model i_flash (.clk(clk), .rstn(rstn), .flashOpStart(flashOpStart),
    .opCycles(8'h0a), .rdAddr(rdAddr), .flashDone(flashDone), .flashRdWord(flashRdWord));

  // --------------------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      stop_test;
    end
  end

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // Register write, taken at the second edge
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    regAddr <= `FSP_CSR_OFFSET;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  // Register read; data stands in the cycle after the request
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    v = {8'h00, regRdData};
  endtask : rd

  task automatic csrChk(input logic [15:0] exp, input string n);
    rd(`FSP_CSR_OFFSET);
    chk(n, v, exp);
  endtask : csrChk

  task automatic spm(input logic [15:0] z, input logic [15:0] w);
    @(posedge clk);
    spmExec <= 1'b1;
    zPointer <= z;
    r1r0Word <= w;
    @(posedge clk);
    spmExec <= 1'b0;
    #1;
  endtask : spm

  // Program load; result is valid flag over the byte
  task automatic ldp(input logic [15:0] z, input logic [7:0] exp, input string n);
    @(posedge clk);
    ldpExec <= 1'b1;
    zPointer <= z;
    rdAddr <= z[14:1];
    @(posedge clk);
    ldpExec <= 1'b0;
    #1;
    chk(n, {7'h00, ldpValid, ldpData}, {8'h01, exp});
  endtask : ldp

  task automatic bufChk(input logic [5:0] i, input logic [15:0] exp, input string n);
    @(posedge clk);
    bufRdIdx <= i;
    @(posedge clk);
    #1;
    chk(n, bufRdData, exp);
  endtask : bufChk

  // Bounded wait for the array to finish, then one edge to settle
  task automatic waitDone;
    int i;
    i = 0;
    while (flashDone !== 1'b1 && i < 100)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    @(posedge clk);
    #1;
  endtask : waitDone

  task automatic stop_test;
    $display("checks %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    bootTab = '{`FSP_BOOT_START_2K, `FSP_BOOT_START_1K, `FSP_BOOT_START_512,
      `FSP_BOOT_START_256};
    {rstn, regWrEn, regRdEn, spmExec, ldpExec, globalIrqEn} = 6'h00;
    {regAddr, bufRdIdx, regWrData, zPointer, r1r0Word, rdAddr, bootSizeSel} = '0;
    fuseBits = 8'ha5;
    sigRowByte = 8'h3c;
    errors = 0;
    testsRun = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // Reset state
    csrChk(16'h0000, "csr reset");
    rd(6'h20);
    chk("unmapped read", v, 16'h0000);
    chk("lock reset", {8'h00, lockBits}, 16'h00ff);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      bootSizeSel <= 2'(c);
      repeat (2) @(posedge clk);
      #1;
      chk("boot start", {2'b00, bootStart}, {2'b00, bootTab[c]});
    end
    $display("test reset and boot size done");
    // Refused pattern, ready request, window expiry
    wr(8'h9f);
    csrChk(16'h0080, "bad pattern");
    @(posedge clk);
    globalIrqEn <= 1'b1;
    @(posedge clk);
    #1;
    chk("irq idle", {15'h0000, readyIrq}, 16'h0001);
    wr(8'h83);
    #1;
    chk("irq armed", {15'h0000, readyIrq}, 16'h0000);
    csrChk(16'h0083, "armed");
    repeat (4) @(posedge clk);
    csrChk(16'h0080, "expired");
    wr(8'h00);
    globalIrqEn <= 1'b0; // Interrupts masked across timed sequences
    $display("test window done");
    // Fill then abort, then fill the first and last word
    wr(8'h01);
    spm(16'h018a, 16'hbeef);
    wr(8'h11);
    bufChk(6'h05, 16'hffff, "aborted fill");
    repeat (4) @(posedge clk);
    for (int w = 0; w < 64; w += 63)
    begin
      wr(8'h01);
      spm({2'b00, 7'h03, 6'(w), 1'b1}, 16'h1200 + 16'(w));
      bufChk(6'(w), 16'h1200 + 16'(w), "fill word");
    end
    csrChk(16'h0000, "fill done");
    // Page write into the concurrent region
    wr(8'h05);
    spm(16'h0180, 16'h0000);
    chk("write start", {7'h00, flashOpStart, flashOpErase, flashPage}, 16'h0103);
    csrChk(16'h0045, "write busy");
    ldp(16'h0020, 8'hff, "blocked load");
    chk("blocked", {15'h0000, rdBlocked}, 16'h0001);
    wr(8'h11);
    csrChk(16'h0045, "reenable refused");
    waitDone;
    csrChk(16'h0040, "write done");
    bufChk(6'h00, 16'hffff, "buffer cleared");
    wr(8'h11);
    spm(16'h0000, 16'h0000);
    csrChk(16'h0000, "reenabled");
    ldp(16'h0021, 8'hef, "high byte");
    $display("test page write done");
    // Erase in the protected region halts the core
    wr(8'h03);
    spm(16'h7000, 16'h0000);
    chk("erase start", {7'h00, flashOpStart, flashOpErase, flashPage}, 16'h01e0);
    chk("halt", {15'h0000, cpuHalt}, 16'h0001);
    csrChk(16'h0003, "no busy");
    waitDone;
    chk("halt end", {15'h0000, cpuHalt}, 16'h0000);
    // Last concurrent page, busy cleared by a buffer fill
    wr(8'h03);
    spm(16'h6f80, 16'h0000);
    csrChk(16'h0043, "edge page busy");
    waitDone;
    wr(8'h01);
    spm(16'h0002, 16'h0000);
    csrChk(16'h0000, "fill clears busy");
    $display("test page erase done");
    // Lock bits, lock and fuse reads, signature row
    wr(8'h09);
    spm(16'h1234, 16'hff24);
    chk("lock write", {8'h00, lockBits}, 16'h00e7);
    csrChk(16'h0000, "lock done");
    wr(8'h09);
    ldp(16'h0000, 8'he7, "lock read");
    repeat (4) @(posedge clk);
    wr(8'h09);
    ldp(16'h0001, 8'ha5, "fuse read");
    repeat (4) @(posedge clk);
    wr(8'h21);
    ldp(16'h0000, 8'h3c, "signature read");
    repeat (4) @(posedge clk);
    wr(8'h21);
    spm(16'h0000, 16'h0000);
    bufChk(6'h00, 16'hffff, "signature store");
    csrChk(16'h0000, "signature done");
    $display("test lock and signature done");
    stop_test;
  end
endmodule : tb
